/* File: logic/rcf_pkg.sv */
/*
 * package of the read-only card command filter: register map, field
 * positions, command numbers and the state types.
 * assumes a 32-bit classic Wishbone slave port and one card bus.
 */
`default_nettype none
package rcf_pkg;
	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_IRQ_STAT = 8'h04;
	localparam logic [7:0] ADR_IRQ_MASK = 8'h08;
	localparam logic [7:0] ADR_CARD_STATE = 8'h0c;
	localparam logic [7:0] ADR_MEDIA_TYPE = 8'h10;
	localparam logic [7:0] ADR_CMD_CLASS = 8'h14;
	localparam logic [7:0] ADR_CARD_CONFIG = 8'h18;
	localparam logic [7:0] ADR_LAST_ARG = 8'h1c;
	// ----------------------------------------------------------------
	// fields and fixed values
	// ----------------------------------------------------------------
	localparam int CTRL_LOCK_SUP = 0;
	localparam int CTRL_SEC_SUP = 1;
	localparam int CTRL_SEC_LO = 8;
	localparam int IRQ_ILLEGAL = 0;
	localparam int IRQ_LOCK_FAIL = 1;
	localparam int IRQ_CMD_DONE = 2;
	localparam int CCC_WRITE = 4;
	localparam int CCC_ERASE = 5;
	localparam int CCC_PROT = 6;
	localparam int CCC_LOCK = 7;
	localparam logic [15:0] MEDIA_TYPE_ROM = 16'h0001;
	localparam logic [11:0] CCC_BASE = 12'h5f5;
	localparam logic PERM_LOCK_VAL = 1'h1;
	localparam logic [3:0] SEC_V0 = 4'h0;
	localparam logic [3:0] SEC_V2 = 4'h2;
	localparam logic [3:0] SEC_V3 = 4'h3;
	localparam logic [3:0] SEC_V4 = 4'h4;
	localparam logic [3:0] LOCK_FN_LOCK = 4'h4;
	localparam logic [3:0] LOCK_FN_UNLOCK = 4'h0;
	localparam logic [5:0] FRAME_LAST = 6'h25;
	// ----------------------------------------------------------------
	// command numbers
	// ----------------------------------------------------------------
	localparam logic [5:0] CMD_GO_IDLE = 6'h00;
	localparam logic [5:0] CMD_LOCK = 6'h2a;
	localparam logic [5:0] CMD_APP = 6'h37;
	localparam logic [5:0] ACMD_SEC_WRITE = 6'h19;
	localparam logic [5:0] ACMD_SEC_ERASE = 6'h26;
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		RCF_RX_IDLE = 1'b0,
		RCF_RX_SHIFT = 1'b1
	} rcf_rx_t;
	typedef struct packed {
		logic [5:0] idx;
		logic [31:0] arg;
	} rcf_cmd_t;
	typedef struct packed {
		rcf_rx_t rx;
		logic [5:0] cnt;
		logic [37:0] shreg;
		logic [2:0] sclk_s;
		logic [1:0] cmd_s;
		logic app;
		logic locked;
		logic cs_illegal;
		logic cs_lock_fail;
		rcf_cmd_t last;
		logic lock_sup;
		logic sec_sup;
		logic [3:0] sec_ver;
		logic [2:0] irq_stat;
		logic [2:0] irq_mask;
		logic ack;
		logic [31:0] dat;
		logic irq;
	} rcf_state_t;
endpackage
`default_nettype wire

/* File: logic/rcf_filter.sv */
/*
 * command filter of a read-only memory card: receives command frames
 * on the card bus, refuses write/erase/protect commands, handles the
 * optional lock and security commands, and presets the capability
 * fields. assumes a classic Wishbone master on clk and a card bus
 * clock well below clk/4, sampled here as an ordinary input.
 */
`timescale 1ns/1ps
`default_nettype none
module rcf_filter import rcf_pkg::*; #(
	parameter logic [15:0] LOCK_PASSWORD = 16'h1234
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	// card bus
	input wire logic card_clk,
	input wire logic card_cmd,
	// interrupt
	output logic irq_o
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	rcf_state_t st_ff;
	rcf_state_t nxt_st;
	localparam rcf_state_t ST_RESET = '0;

	logic frame_done;
	rcf_cmd_t cmd;
	logic [3:0] lock_fn;
	logic pwd_ok;
	logic bad_cmd;
	logic lock_bad;
	logic [11:0] cmd_class;
	logic [3:0] sec_field;
	logic [31:0] wmask;
	logic [31:0] rdata;
	logic wr_fire;
	logic [2:0] ev_set;
	logic [2:0] ev_clr;

	assign wb_ack_o = st_ff.ack;
	assign wb_dat_o = st_ff.dat;
	assign irq_o = st_ff.irq;

	// ----------------------------------------------------------------
	// command decoders
	// ----------------------------------------------------------------
	function automatic logic rcf_is_unsup(input logic [5:0] idx);
		unique case (idx)
			6'h18, 6'h19, 6'h1b, 6'h1c, 6'h1d, 6'h1e, 6'h20, 6'h21,
			6'h26: rcf_is_unsup = 1'b1;
			default: rcf_is_unsup = 1'b0;
		endcase
	endfunction

	function automatic logic rcf_is_sec(input logic [5:0] idx);
		unique case (idx)
			6'h12, 6'h19, 6'h1a, 6'h26, 6'h2b, 6'h2c, 6'h2d, 6'h2e,
			6'h2f, 6'h30, 6'h31: rcf_is_sec = 1'b1;
			default: rcf_is_sec = 1'b0;
		endcase
	endfunction

	function automatic logic rcf_sec_legal(input logic [3:0] v);
		rcf_sec_legal = (v == SEC_V0) || (v == SEC_V2) ||
			(v == SEC_V3) || (v == SEC_V4);
	endfunction

	// ----------------------------------------------------------------
	// capability fields from fixed values and the control register
	// ----------------------------------------------------------------
	always_comb begin
		cmd_class = CCC_BASE;
		cmd_class[CCC_WRITE] = 1'b0;
		cmd_class[CCC_ERASE] = 1'b0;
		cmd_class[CCC_PROT] = 1'b0;
		cmd_class[CCC_LOCK] = st_ff.lock_sup;
		sec_field = st_ff.sec_sup ? st_ff.sec_ver : SEC_V0;
	end

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	always_comb begin
		wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
			{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
		wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && st_ff.ack;
		rdata = '0;
		unique case (wb_adr_i)
			ADR_CTRL: begin
				rdata[CTRL_LOCK_SUP] = st_ff.lock_sup;
				rdata[CTRL_SEC_SUP] = st_ff.sec_sup;
				rdata[CTRL_SEC_LO +: 4] = st_ff.sec_ver;
			end
			ADR_IRQ_STAT: rdata[2:0] = st_ff.irq_stat;
			ADR_IRQ_MASK: rdata[2:0] = st_ff.irq_mask;
			ADR_CARD_STATE: begin
				rdata[0] = st_ff.locked;
				rdata[1] = st_ff.app;
				rdata[2] = st_ff.cs_illegal;
				rdata[3] = st_ff.cs_lock_fail;
				rdata[13:8] = st_ff.last.idx;
			end
			ADR_MEDIA_TYPE: rdata[15:0] = MEDIA_TYPE_ROM;
			ADR_CMD_CLASS: rdata[11:0] = cmd_class;
			ADR_CARD_CONFIG: begin
				rdata[0] = PERM_LOCK_VAL;
				rdata[7:4] = sec_field;
			end
			ADR_LAST_ARG: rdata = st_ff.last.arg;
			default: rdata = '0;
		endcase
	end

	// ----------------------------------------------------------------
	// command classification
	// ----------------------------------------------------------------
	always_comb begin
		frame_done = (st_ff.rx == RCF_RX_SHIFT) &&
			st_ff.sclk_s[1] && !st_ff.sclk_s[2] &&
			(st_ff.cnt == FRAME_LAST);
		cmd = {st_ff.shreg[36:0], st_ff.cmd_s[1]};
		lock_fn = cmd.arg[3:0];
		pwd_ok = (cmd.arg[31:16] == LOCK_PASSWORD);
		bad_cmd = 1'b0;
		if (!st_ff.app && rcf_is_unsup(cmd.idx)) begin
			bad_cmd = 1'b1;
		end
		if (!st_ff.app && cmd.idx == CMD_LOCK && !st_ff.lock_sup) begin
			bad_cmd = 1'b1;
		end
		if (st_ff.app && rcf_is_sec(cmd.idx) && !st_ff.sec_sup) begin
			bad_cmd = 1'b1;
		end
		if (st_ff.app && (cmd.idx == ACMD_SEC_WRITE ||
			cmd.idx == ACMD_SEC_ERASE)) begin
			bad_cmd = 1'b1;
		end
		lock_bad = !st_ff.app && cmd.idx == CMD_LOCK && st_ff.lock_sup &&
			!(pwd_ok && (lock_fn == LOCK_FN_LOCK ||
			lock_fn == LOCK_FN_UNLOCK));
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_st.sclk_s = {st_ff.sclk_s[1:0], card_clk};
		nxt_st.cmd_s = {st_ff.cmd_s[0], card_cmd};
		// frame receiver: start bit low, 6 index bits, 32 argument bits
		if (st_ff.sclk_s[1] && !st_ff.sclk_s[2]) begin
			unique case (st_ff.rx)
				RCF_RX_IDLE: begin
					if (!st_ff.cmd_s[1]) begin
						nxt_st.rx = RCF_RX_SHIFT;
						nxt_st.cnt = '0;
					end
				end
				RCF_RX_SHIFT: begin
					nxt_st.shreg = {st_ff.shreg[36:0], st_ff.cmd_s[1]};
					nxt_st.cnt = st_ff.cnt + 6'h01;
					if (st_ff.cnt == FRAME_LAST) begin
						nxt_st.rx = RCF_RX_IDLE;
					end
				end
			endcase
		end
		ev_set = '0;
		if (frame_done) begin
			nxt_st.last = cmd;
			nxt_st.cs_illegal = bad_cmd;
			nxt_st.cs_lock_fail = lock_bad;
			ev_set[IRQ_CMD_DONE] = 1'b1;
			ev_set[IRQ_ILLEGAL] = bad_cmd;
			ev_set[IRQ_LOCK_FAIL] = lock_bad;
			if (!bad_cmd) begin
				nxt_st.app = !st_ff.app && cmd.idx == CMD_APP;
				if (!st_ff.app && cmd.idx == CMD_LOCK && !lock_bad) begin
					nxt_st.locked = (lock_fn == LOCK_FN_LOCK);
				end
				if (!st_ff.app && cmd.idx == CMD_GO_IDLE) begin
					nxt_st.locked = ST_RESET.locked;
					nxt_st.app = ST_RESET.app;
					nxt_st.cs_illegal = ST_RESET.cs_illegal;
					nxt_st.cs_lock_fail = ST_RESET.cs_lock_fail;
				end
			end
		end
		// registers, written at the acknowledging edge
		ev_clr = '0;
		if (wr_fire && wb_adr_i == ADR_CTRL) begin
			if (wb_sel_i[0]) begin
				nxt_st.lock_sup = wb_dat_i[CTRL_LOCK_SUP];
				nxt_st.sec_sup = wb_dat_i[CTRL_SEC_SUP];
			end
			if (wb_sel_i[1] && rcf_sec_legal(wb_dat_i[CTRL_SEC_LO +: 4])) begin
				nxt_st.sec_ver = wb_dat_i[CTRL_SEC_LO +: 4];
			end
		end
		if (wr_fire && wb_adr_i == ADR_IRQ_MASK && wb_sel_i[0]) begin
			nxt_st.irq_mask = wb_dat_i[2:0];
		end
		if (wr_fire && wb_adr_i == ADR_IRQ_STAT) begin
			ev_clr = wb_dat_i[2:0] & wmask[2:0];
		end
		// set wins over a simultaneous clear
		nxt_st.irq_stat = (st_ff.irq_stat & ~ev_clr) | ev_set;
		nxt_st.irq = |(st_ff.irq_stat & st_ff.irq_mask);
		nxt_st.ack = wb_cyc_i && wb_stb_i && !st_ff.ack;
		nxt_st.dat = (wb_cyc_i && wb_stb_i && !st_ff.ack) ? rdata : '0;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_ff <= ST_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_ack_single: assert property (@(posedge clk) disable iff (!resetn)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_ack_latency: assert property (@(posedge clk) disable iff (!resetn)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("ack not given one cycle after request");
	a_class_bits: assert property (@(posedge clk) disable iff (!resetn)
		cmd_class[CCC_PROT:CCC_WRITE] == 3'h0 &&
		(wb_adr_i != ADR_MEDIA_TYPE || rdata[15:0] == MEDIA_TYPE_ROM))
		else $error("write classes advertised or media type lost");
	a_lock_class: assert property (@(posedge clk) disable iff (!resetn)
		!st_ff.lock_sup |-> !cmd_class[CCC_LOCK])
		else $error("lock class advertised without lock support");
	a_sec_version: assert property (@(posedge clk) disable iff (!resetn)
		rcf_sec_legal(sec_field) && (st_ff.sec_sup || sec_field == 4'h0))
		else $error("illegal security version shown");
	a_unsup_illegal: assert property (@(posedge clk) disable iff (!resetn)
		(frame_done && !st_ff.app && rcf_is_unsup(cmd.idx)) |=>
		st_ff.cs_illegal && $stable(st_ff.locked) && st_ff.irq_stat[0])
		else $error("unsupported command not refused");
	a_nolock_illegal: assert property (@(posedge clk) disable iff (!resetn)
		(frame_done && !st_ff.app && cmd.idx == CMD_LOCK &&
		!st_ff.lock_sup) |=> st_ff.cs_illegal && $stable(st_ff.locked))
		else $error("lock command acted on without support");
	a_sec_illegal: assert property (@(posedge clk) disable iff (!resetn)
		(frame_done && st_ff.app && rcf_is_sec(cmd.idx) &&
		!st_ff.sec_sup) |=> st_ff.cs_illegal)
		else $error("security command accepted without support");
	a_prot_refuse: assert property (@(posedge clk) disable iff (!resetn)
		(frame_done && st_ff.app && (cmd.idx == ACMD_SEC_WRITE ||
		cmd.idx == ACMD_SEC_ERASE)) |=> st_ff.cs_illegal && st_ff.app)
		else $error("protected area write not refused");
	a_lock_fail: assert property (@(posedge clk) disable iff (!resetn)
		(frame_done && !st_ff.app && cmd.idx == CMD_LOCK &&
		st_ff.lock_sup && lock_fn != LOCK_FN_LOCK &&
		lock_fn != LOCK_FN_UNLOCK) |=> st_ff.cs_lock_fail ##1 irq_o ||
		!st_ff.irq_mask[IRQ_LOCK_FAIL])
		else $error("unsupported lock function not flagged");
	a_lock_preset: assert property (@(posedge clk) disable iff (!resetn)
		(frame_done && !st_ff.app && cmd.idx == CMD_LOCK &&
		st_ff.lock_sup && pwd_ok && lock_fn == LOCK_FN_LOCK) |=>
		st_ff.locked)
		else $error("lock with preset password did not lock");
	a_bad_keeps: assert property (@(posedge clk) disable iff (!resetn)
		(frame_done && bad_cmd) |=> $stable(st_ff.locked) &&
		st_ff.cs_illegal)
		else $error("refused command changed card state");
	a_go_idle: assert property (@(posedge clk) disable iff (!resetn)
		(frame_done && !st_ff.app && cmd.idx == CMD_GO_IDLE) |=>
		!st_ff.locked && !st_ff.app && !st_ff.cs_illegal)
		else $error("go-idle did not restore initial state");
	a_irq_level: assert property (@(posedge clk) disable iff (!resetn)
		##1 irq_o == |($past(st_ff.irq_stat) & $past(st_ff.irq_mask)))
		else $error("interrupt does not follow masked status");
	a_dat_idle: assert property (@(posedge clk) disable iff (!resetn)
		!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data shown without ack");
	a_perm_lock: assert property (@(posedge clk) disable iff (!resetn)
		(wb_ack_o && !wb_we_i && wb_adr_i == ADR_CARD_CONFIG) |->
		wb_dat_o[0] == PERM_LOCK_VAL)
		else $error("permanent lock bit not shown as set");
	a_media_read: assert property (@(posedge clk) disable iff (!resetn)
		(wb_ack_o && !wb_we_i && wb_adr_i == ADR_MEDIA_TYPE) |->
		wb_dat_o[15:0] == MEDIA_TYPE_ROM)
		else $error("media type read back wrong");
	a_stat_set: assert property (@(posedge clk) disable iff (!resetn)
		(|ev_set) |=> (st_ff.irq_stat & $past(ev_set)) == $past(ev_set))
		else $error("event lost against a clear");
	a_frame_cnt: assert property (@(posedge clk) disable iff (!resetn)
		st_ff.rx == RCF_RX_SHIFT |-> st_ff.cnt <= FRAME_LAST)
		else $error("frame counter ran past the last bit");
	a_cmd_done: assert property (@(posedge clk) disable iff (!resetn)
		frame_done |=> st_ff.irq_stat[IRQ_CMD_DONE] &&
		st_ff.last == $past(cmd))
		else $error("finished frame not recorded");
	a_unlock_done: assert property (@(posedge clk) disable iff (!resetn)
		(frame_done && !st_ff.app && cmd.idx == CMD_LOCK &&
		st_ff.lock_sup && pwd_ok && lock_fn == LOCK_FN_UNLOCK) |=>
		!st_ff.locked)
		else $error("unlock with preset password did not unlock");
	a_bad_password: assert property (@(posedge clk) disable iff (!resetn)
		(frame_done && !st_ff.app && cmd.idx == CMD_LOCK && !pwd_ok) |=>
		$stable(st_ff.locked))
		else $error("lock state changed on a wrong password");
	a_sec_write: assert property (@(posedge clk) disable iff (!resetn)
		(wr_fire && wb_adr_i == ADR_CTRL && wb_sel_i[1] &&
		!rcf_sec_legal(wb_dat_i[CTRL_SEC_LO +: 4])) |=>
		$stable(st_ff.sec_ver))
		else $error("illegal security version stored");
	a_irq_clear: assert property (@(posedge clk) disable iff (!resetn)
		(wr_fire && wb_adr_i == ADR_IRQ_STAT && !frame_done) |=>
		(st_ff.irq_stat & $past(wb_dat_i[2:0] & wmask[2:0])) == 3'h0)
		else $error("status bit not cleared by a one");
endmodule
`default_nettype wire

/* File: tb/rcf_host_model.sv */
/*
 * host side of the card bus: sends command frames.
 * assumes the filter's clk; card clock period is 8 clk periods.
 */
`timescale 1ns/1ps
`default_nettype none
module rcf_host_model (
	// clock
	input wire logic clk,
	// card bus
	output logic card_clk,
	output logic card_cmd
);
	initial begin
		card_clk = 1'b0;
		card_cmd = 1'b1;
	end
	// start bit, index, argument; clock stands low between frames
	task automatic send(input logic [5:0] i, input logic [31:0] a);
		logic [38:0] f;
		f = {1'b0, i, a};
		for (int k = 38; k >= 0; k--) begin
			@(posedge clk);
			card_clk <= 1'b0;
			card_cmd <= f[k];
			repeat (4) @(posedge clk);
			card_clk <= 1'b1;
			repeat (3) @(posedge clk);
		end
		@(posedge clk);
		card_clk <= 1'b0;
		card_cmd <= 1'b1;
	endtask
endmodule
`default_nettype wire

/* File: tb/rcf_filter_tb.sv */
/*
 * self-checking bench of the card command filter.
 * assumes rcf_host_model drives the card bus.
 */
`timescale 1ns/1ps
`default_nettype none
module rcf_filter_tb import rcf_pkg::*;;
	localparam logic [15:0] PW = 16'hc35a;
	logic clk = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wd = 32'h0, q, rq;
	logic ack, irq, cclk, ccmd, lk, ss, locked, app;
	logic [3:0] sv;
	logic [31:0] seed = 32'ha3fee682;
	// byte lanes driven with the next access
	logic [3:0] sel = 4'hf, bsel = 4'hf;
	logic [5:0] r_list [9] = '{6'd24, 6'd25, 6'd27, 6'd28, 6'd29, 6'd30,
		6'd32, 6'd33, 6'd38};
	logic [5:0] s_list [11] = '{6'd18, 6'd25, 6'd26, 6'd38, 6'd43, 6'd44,
		6'd45, 6'd46, 6'd47, 6'd48, 6'd49};
	int mismatches = 0, n_tests = 0;
	always #12.5 clk = ~clk;
	rcf_filter #(.LOCK_PASSWORD(PW)) i_dut (.clk(clk), .resetn(resetn),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wd), .wb_ack_o(ack), .wb_dat_o(q),
		.card_clk(cclk), .card_cmd(ccmd), .irq_o(irq));
	rcf_host_model i_host (.clk(clk), .card_clk(cclk), .card_cmd(ccmd));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] nx();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic unsup(input logic [5:0] i);
		return i inside {6'd24, 6'd25, 6'd27, 6'd28, 6'd29, 6'd30, 6'd32,
			6'd33, 6'd38};
	endfunction
	task automatic tally_and_finish();
		$display("mismatches %0d of %0d checks", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		sel <= bsel;
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		rq = q;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(rq, e);
	endtask
	task automatic ctl(input logic l, input logic s, input logic [3:0] v);
		lk = l;
		ss = s;
		if (v inside {SEC_V0, SEC_V2, SEC_V3, SEC_V4})
			sv = v;
		wb(1'b1, ADR_CTRL, {20'h0, v, 6'h0, s, l});
	endtask
	task automatic rst();
		@(posedge clk);
		resetn <= 1'b0;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		{lk, ss, locked, app, sv} = 8'h00;
	endtask
	task automatic ci(input logic e);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk({31'h0, irq}, {31'h0, e});
	endtask
	task automatic cfg_chk();
		rc(ADR_CMD_CLASS, {20'h0, CCC_BASE & 12'hf0f} | (lk << 7));
		rc(ADR_CARD_CONFIG, {24'h0, ss ? sv : 4'h0, 4'h1});
	endtask
	task automatic cmd(input logic [5:0] i, input logic [31:0] a);
		logic bad, fail;
		logic [31:0] m;
		bad = app ? (!ss || i == 6'd25 || i == 6'd38)
			: (unsup(i) || (i == CMD_LOCK && !lk));
		fail = 1'b0;
		// app pending after a refused app command is left unchecked
		m = (app && bad) ? 32'hffff_fffd : 32'hffff_ffff;
		if (!app && !bad && i == CMD_LOCK) begin
			if (a[31:16] == PW && a[3:0] inside {LOCK_FN_LOCK, LOCK_FN_UNLOCK})
				locked = (a[3:0] == LOCK_FN_LOCK);
			else
				fail = 1'b1;
		end
		if (!app && i == CMD_GO_IDLE)
			locked = 1'b0;
		app = (app && bad) || (!app && !bad && i == CMD_APP);
		i_host.send(i, a);
		repeat (8) @(posedge clk);
		wb(1'b0, ADR_CARD_STATE, 32'h0);
		chk(rq & m, {18'h0, i, 4'h0, fail, bad, app, locked} & m);
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		logic [5:0] r;
		logic [31:0] t;
		rst();
		rc(ADR_MEDIA_TYPE, {16'h0, MEDIA_TYPE_ROM});
		wb(1'b1, ADR_MEDIA_TYPE, nx());
		rc(ADR_MEDIA_TYPE, 32'h1);
		rc(8'h20, 32'h0);
		cfg_chk();
		for (int v = 0; v < 16; v++) begin
			ctl(1'b0, 1'b1, v[3:0]);
			cfg_chk();
		end
		ctl(1'b0, 1'b0, 4'h3);
		cfg_chk();
		foreach (r_list[k])
			cmd(r_list[k], nx());
		cmd(CMD_LOCK, {PW, 16'h0004});
		wb(1'b1, ADR_IRQ_STAT, 32'h7);
		wb(1'b1, ADR_IRQ_MASK, 32'h1);
		ci(1'b0);
		cmd(6'd24, nx());
		ci(1'b1);
		rc(ADR_IRQ_STAT, 32'h5);
		bsel = 4'he;
		wb(1'b1, ADR_IRQ_MASK, 32'h7);
		bsel = 4'hf;
		rc(ADR_IRQ_MASK, 32'h1);
		wb(1'b1, ADR_IRQ_MASK, 32'h0);
		ci(1'b0);
		wb(1'b1, ADR_IRQ_MASK, 32'h5);
		ci(1'b1);
		wb(1'b1, ADR_IRQ_STAT, 32'h1);
		ci(1'b1);
		wb(1'b1, ADR_IRQ_STAT, 32'h4);
		ci(1'b0);
		ctl(1'b1, 1'b0, 4'h0);
		cfg_chk();
		cmd(CMD_LOCK, {PW, 16'h0004});
		cmd(CMD_LOCK, {~PW, 16'h0000});
		cmd(CMD_LOCK, {PW, 16'h0007});
		rc(ADR_IRQ_STAT, 32'h6);
		cmd(CMD_LOCK, {PW, 16'h0000});
		cmd(CMD_LOCK, {PW, 16'h0004});
		cmd(CMD_GO_IDLE, 32'h0);
		for (int s = 0; s < 2; s++) begin
			foreach (s_list[k]) begin
				ctl(1'b0, s[0], 4'h2);
				cmd(CMD_APP, nx());
				cmd(s_list[k], nx());
				if (!ss || s_list[k] inside {6'd25, 6'd38})
					rst();
				else
					cmd(CMD_GO_IDLE, 32'h0);
			end
		end
		repeat (12) begin
			t = nx();
			r = t[5:0];
			if (!(r inside {6'd0, 6'd18, 6'd26, [6'd42:6'd49], 6'd55}))
				cmd(r, nx());
		end
		tally_and_finish();
	end
	initial begin
		#2000000;
		mismatches++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
